// ### rtl/audio_fifo_irq_sync_ctrl.sv
// audio fifo pairing, auto-resync, tick and interrupt status logic
// How it works
// - one auto-resync enable bit per fifo in global control, 1 enables
// - tick count field bits 5:3 gives one to five events per tick
// - tick source field bit 11 over bits 2:0 picks event, zero is off
// - selected events are counted and a tick fires per programmed count
// - tick counting ignores fifo reset state
// - bursts of two samples; resync waits one sample clock after access
// - input pair full only when both halves are full
// - input pair under/overrun flag on either half's xrun
// - resync flag set whenever hardware realigns a pair
// - left and right halves handled independently, each in order
// - output pair empty only when both halves are empty
// - output pair under/overrun flag on either half's xrun
// - audio-side xrun never breaks left/right alignment
// - status 31:26 hold transmit xrun and resync flags, clear register
// - status 25:22 hold receiver events, clear register
// - status 21:17 user channel; 21,19 clear on tx write, 18 on rx read
// - status 16 clears on subcode read; 15:13 via clear register
// - status 12:9 input fifo 1 and 2 xrun and resync flags
// - resync machine off/standby/on; on mismatch load right from left
// - cpu access forces off; left audio to standby; right audio to on
// - xrun on one input half drops the next sample of the other
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module audio_fifo_irq_sync_ctrl (
  input  wire logic                                   SYS_CLK,
  input  wire logic                                   RST_N,
  input  wire logic                                   PSEL,
  input  wire logic                                   PENABLE,
  input  wire logic                                   PWRITE,
  input  wire logic [audio_irq_pkg::ADDR_W-1:0]       PADDR,
  input  wire logic [audio_irq_pkg::DATA_W-1:0]       PWDATA,
  output logic      [audio_irq_pkg::DATA_W-1:0]       PRDATA,
  output logic                                        PREADY,
  output logic                                        PSLVERR,
  input  wire logic                                   SAMPLE_TICK,
  input  wire logic [7:0]                             TICK_EVENTS,
  input  wire logic [audio_irq_pkg::FIFO_N-1:0]       CPU_ACCESS,
  input  wire logic [audio_irq_pkg::FIFO_N-1:0]       CPU_XRUN,
  input  wire logic [audio_irq_pkg::FIFO_N-1:0]       LEFT_AUDIO,
  input  wire logic [audio_irq_pkg::FIFO_N-1:0]       RIGHT_AUDIO,
  input  wire logic [audio_irq_pkg::FIFO_N-1:0]       XRUN_LEFT,
  input  wire logic [audio_irq_pkg::FIFO_N-1:0]       XRUN_RIGHT,
  input  wire logic [17:0]                            LEFT_LEVEL,
  input  wire logic [17:0]                            RIGHT_LEVEL,
  input  wire logic [2:0]                             IN_LEFT_FULL,
  input  wire logic [2:0]                             IN_RIGHT_FULL,
  input  wire logic [2:0]                             TX_LEFT_EMPTY,
  input  wire logic [2:0]                             TX_RIGHT_EMPTY,
  input  wire logic [12:0]                            RX_EVENT_SET,
  input  wire logic                                   USER_TX_WRITE,
  input  wire logic                                   USER_RX_READ,
  input  wire logic                                   SUBCODE_RX_READ,
  output logic      [2:0]                             IN_FULL,
  output logic      [2:0]                             TX_EMPTY,
  output logic      [audio_irq_pkg::FIFO_N-1:0]       RESYNC_LOAD,
  output logic      [audio_irq_pkg::FIFO_N-1:0]       DROP_LEFT,
  output logic      [audio_irq_pkg::FIFO_N-1:0]       DROP_RIGHT,
  output logic                                        TICK_IRQ,
  output logic                                        AUDIO_IRQ
);
  import audio_irq_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction : hit

  function automatic logic [LEVEL_W-1:0] level_of(input logic [17:0] v, input int i);
    level_of = v[i*LEVEL_W +: LEVEL_W];
  endfunction : level_of

  function automatic logic sync_enable(input logic [15:0] c, input int i);
    case (i)
      F_IN1:   sync_enable = c[AS_IN1];
      F_IN2:   sync_enable = c[AS_IN2];
      F_IN3:   sync_enable = c[AS_IN3];
      F_TX1:   sync_enable = c[AS_TX1];
      F_TX2:   sync_enable = c[AS_TX2];
      default: sync_enable = c[AS_SPDIF];
    endcase
  endfunction : sync_enable

  logic [15:0]       ctrl;
  logic [31:0]       stat;
  logic [1:0]        in3_flags;
  rs_state_t         rs_state [FIFO_N];
  logic [FIFO_N-1:0] quiet_wait;
  logic [2:0]        tick_cnt;
  logic [3:0]        tick_src;
  logic [2:0]        tick_len;
  logic              tick_event;
  logic              wr_take;
  logic              clr_take;
  logic              fs_clr_take;
  logic [31:0]       next_stat;
  logic [31:0]       set_v;
  logic [31:0]       clr_v;
  logic [FIFO_N-1:0] uo_ev;

  // ----------------------------------------------------------------
  // apb slave, zero wait state
  // ----------------------------------------------------------------
  assign wr_take     = PSEL && PENABLE && PREADY && PWRITE;
  assign clr_take    = wr_take && hit(PADDR, IDX_IRQ_CLEAR);
  assign fs_clr_take = wr_take && hit(PADDR, IDX_FIFO_STATE);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      PREADY  <= 1'b1;
      PSLVERR <= !(hit(PADDR, IDX_GLOBAL_CTRL) || hit(PADDR, IDX_IRQ_STATUS) ||
                   hit(PADDR, IDX_IRQ_CLEAR) || hit(PADDR, IDX_FIFO_STATE));
      if (hit(PADDR, IDX_GLOBAL_CTRL)) begin
        PRDATA <= {16'h0000, ctrl};
      end else if (hit(PADDR, IDX_IRQ_STATUS)) begin
        PRDATA <= stat;
      end else if (hit(PADDR, IDX_FIFO_STATE)) begin
        PRDATA <= {24'h00_0000, TX_EMPTY, IN_FULL, in3_flags};
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= CTRL_RESET;
    end else if (wr_take && hit(PADDR, IDX_GLOBAL_CTRL)) begin
      ctrl <= PWDATA[15:0] & CTRL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // audio tick
  // ----------------------------------------------------------------
  assign tick_src = {ctrl[TSRC_HI], ctrl[TSRC_MSB:TSRC_LSB]};
  assign tick_len = ctrl[TCNT_MSB:TCNT_LSB];

  always_comb begin
    if (tick_src == TSRC_OFF || tick_src == TSRC_RESERVED || tick_src > TSRC_LAST) begin
      tick_event = 1'b0;
    end else begin
      tick_event = TICK_EVENTS[3'(tick_src - 4'h1)];
    end
  end

  // no fifo reset enters here, so ticks keep running through it
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt <= 3'h0;
      TICK_IRQ <= 1'b0;
    end else if (tick_len > TCNT_MAX) begin
      tick_cnt <= 3'h0;
      TICK_IRQ <= 1'b0;
    end else if (tick_event) begin
      // a count lowered under the running counter fires now, never wraps
      TICK_IRQ <= (tick_cnt >= tick_len);
      tick_cnt <= (tick_cnt >= tick_len) ? 3'h0 : tick_cnt + 3'h1;
    end else begin
      TICK_IRQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pair flags
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      IN_FULL  <= 3'h0;
      TX_EMPTY <= 3'h0;
    end else begin
      IN_FULL  <= IN_LEFT_FULL & IN_RIGHT_FULL;
      TX_EMPTY <= TX_LEFT_EMPTY & TX_RIGHT_EMPTY;
    end
  end

  // each half has its own pending drop, so either read order works
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DROP_LEFT  <= '0;
      DROP_RIGHT <= '0;
    end else begin
      DROP_LEFT  <= XRUN_RIGHT | (DROP_LEFT & ~LEFT_AUDIO);
      DROP_RIGHT <= XRUN_LEFT | (DROP_RIGHT & ~RIGHT_AUDIO);
    end
  end

  // ----------------------------------------------------------------
  // auto-resync controllers
  // ----------------------------------------------------------------
  // a left strobe must not enter standby until a sample tick follows a cpu access
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      quiet_wait <= '0;
    end else begin
      for (int i = 0; i < FIFO_N; i++) begin
        if (CPU_ACCESS[i]) begin
          quiet_wait[i] <= 1'b1;
        end else if (SAMPLE_TICK) begin
          quiet_wait[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < FIFO_N; i++) begin
        rs_state[i] <= RS_OFF;
      end
      RESYNC_LOAD <= '0;
    end else begin
      for (int i = 0; i < FIFO_N; i++) begin
        RESYNC_LOAD[i] <= 1'b0;
        if (!sync_enable(ctrl, i) || CPU_ACCESS[i]) begin
          rs_state[i] <= RS_OFF;
        end else if (LEFT_AUDIO[i] && !quiet_wait[i]) begin
          rs_state[i] <= RS_STANDBY;
        end else begin
          unique case (rs_state[i])
            RS_OFF: begin
              rs_state[i] <= RS_OFF;
            end
            RS_STANDBY: begin
              if (RIGHT_AUDIO[i]) begin
                rs_state[i] <= RS_ON;
              end
            end
            RS_ON: begin
              // back to standby so one mismatch gives one load
              if (level_of(LEFT_LEVEL, i) != level_of(RIGHT_LEVEL, i)) begin
                RESYNC_LOAD[i] <= 1'b1;
                rs_state[i]    <= RS_STANDBY;
              end
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  assign uo_ev = XRUN_LEFT | XRUN_RIGHT | CPU_XRUN;

  always_comb begin
    set_v                 = 32'h0000_0000;
    set_v[ST_TX1_UO]      = uo_ev[F_TX1];
    set_v[ST_TX1_RS]      = RESYNC_LOAD[F_TX1];
    set_v[ST_TX2_UO]      = uo_ev[F_TX2];
    set_v[ST_TX2_RS]      = RESYNC_LOAD[F_TX2];
    set_v[ST_SPD_UO]      = uo_ev[F_SPDIF];
    set_v[ST_SPD_RS]      = RESYNC_LOAD[F_SPDIF];
    set_v[ST_RX_MSB:ST_RX_LSB] = RX_EVENT_SET;
    set_v[ST_IN1_UO]      = uo_ev[F_IN1];
    set_v[ST_IN1_RS]      = RESYNC_LOAD[F_IN1];
    set_v[ST_IN2_UO]      = uo_ev[F_IN2];
    set_v[ST_IN2_RS]      = RESYNC_LOAD[F_IN2];
    set_v[ST_TICK]        = TICK_IRQ;
    clr_v                 = clr_take ? (PWDATA & ~ST_SELF_CLR) : 32'h0000_0000;
    clr_v[ST_UTX_EMPTY]   = USER_TX_WRITE;
    clr_v[ST_UTX_FIRST]   = USER_TX_WRITE;
    clr_v[ST_URX_FULL]    = USER_RX_READ;
    clr_v[ST_QRX_FULL]    = SUBCODE_RX_READ;
    // an event in the clearing cycle survives
    next_stat = ((stat & ~clr_v) | set_v) & ST_IMPL_MASK;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat      <= 32'h0000_0000;
      AUDIO_IRQ <= 1'b0;
    end else begin
      stat      <= next_stat;
      AUDIO_IRQ <= |next_stat;
    end
  end

  // input fifo 3 has no slot in the status word
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      in3_flags <= 2'h0;
    end else begin
      in3_flags[FS_IN3_UO] <= uo_ev[F_IN3] |
        (in3_flags[FS_IN3_UO] & ~(fs_clr_take & PWDATA[FS_IN3_UO]));
      in3_flags[FS_IN3_RS] <= RESYNC_LOAD[F_IN3] |
        (in3_flags[FS_IN3_RS] & ~(fs_clr_take & PWDATA[FS_IN3_RS]));
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_full_both: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IN_FULL[0] == $past(IN_LEFT_FULL[0] && IN_RIGHT_FULL[0]))
    else $error("input full flag not the and of both halves");

  chk_empty_both: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (TX_LEFT_EMPTY[0] && !TX_RIGHT_EMPTY[0]) |=> !TX_EMPTY[0])
    else $error("output empty with one half still holding data");

  chk_in1_xrun_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    XRUN_RIGHT[F_IN1] |=> stat[ST_IN1_UO] && DROP_LEFT[F_IN1])
    else $error("input xrun did not flag or drop the other half");

  chk_resync_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    RESYNC_LOAD[F_IN1] |=> stat[ST_IN1_RS] && AUDIO_IRQ)
    else $error("resync load did not set its flag");

  chk_tick_every: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (tick_len == 3'h0 && tick_src == 4'h1 && TICK_EVENTS[0]) |=> TICK_IRQ)
    else $error("tick missing with count of one");

  chk_tick_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (tick_src == TSRC_OFF) [*2] |-> !TICK_IRQ)
    else $error("tick raised with source off");

  chk_flag_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (stat[ST_TX1_UO] && !(clr_take && PWDATA[ST_TX1_UO])) |=> stat[ST_TX1_UO])
    else $error("status flag dropped without a clear");

  chk_disabled_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !ctrl[AS_IN1] [*2] |-> !RESYNC_LOAD[F_IN1])
    else $error("resync load while auto-resync disabled");

  chk_cpu_forces_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CPU_ACCESS[F_IN1] |=> !RESYNC_LOAD[F_IN1] ##1 !RESYNC_LOAD[F_IN1])
    else $error("resync acted right after a processor access");

  chk_user_tx_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (USER_TX_WRITE && !RX_EVENT_SET[ST_UTX_EMPTY-ST_RX_LSB]) |=> !stat[ST_UTX_EMPTY])
    else $error("user tx empty not cleared by transmit write");

  chk_drop_right_set: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    XRUN_LEFT[F_IN3] |=> DROP_RIGHT[F_IN3])
    else $error("left xrun did not block the next right sample");

  chk_in3_xrun_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    XRUN_LEFT[F_IN3] |=> in3_flags[FS_IN3_UO])
    else $error("input fifo 3 xrun not flagged");

  chk_standby_to_on: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (rs_state[F_IN1] == RS_STANDBY && RIGHT_AUDIO[F_IN1] && ctrl[AS_IN1] &&
     !CPU_ACCESS[F_IN1] && !LEFT_AUDIO[F_IN1]) |=> rs_state[F_IN1] == RS_ON)
    else $error("right audio strobe did not arm the resync check");

  chk_load_one_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    RESYNC_LOAD[F_IN1] |=> !RESYNC_LOAD[F_IN1])
    else $error("resync load longer than one cycle");

  chk_tick_reserved: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (tick_len > TCNT_MAX) [*2] |-> !TICK_IRQ)
    else $error("tick raised with a reserved count");

  chk_clear_takes: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (clr_take && PWDATA[ST_TX1_UO] && !uo_ev[F_TX1]) |=> !stat[ST_TX1_UO])
    else $error("clear register did not clear the flag");

  chk_tx_xrun_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    XRUN_LEFT[F_TX1] |=> stat[ST_TX1_UO])
    else $error("output half xrun did not set the pair flag");

  chk_irq_follows: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    AUDIO_IRQ == |stat)
    else $error("interrupt line differs from the status word");
endmodule : audio_fifo_irq_sync_ctrl

// ### rtl/audio_irq_pkg.sv
// constants for the audio fifo control and interrupt block
package audio_irq_pkg;
  // ----------------------------------------------------------------
  // bus
  // ----------------------------------------------------------------
  localparam int         ADDR_W         = 12;
  localparam int         DATA_W         = 32;
  // word indices; byte address is four times the index
  localparam logic [9:0] IDX_GLOBAL_CTRL = 10'h0ce;
  localparam logic [9:0] IDX_IRQ_STATUS  = 10'h0d0;
  localparam logic [9:0] IDX_IRQ_CLEAR   = 10'h0d1;
  localparam logic [9:0] IDX_FIFO_STATE  = 10'h0d2;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_MASK      = 16'h1fff;

  // ----------------------------------------------------------------
  // fifo numbering and control fields
  // ----------------------------------------------------------------
  localparam int FIFO_N   = 6;
  localparam int F_IN1    = 0;
  localparam int F_IN2    = 1;
  localparam int F_IN3    = 2;
  localparam int F_TX1    = 3;
  localparam int F_TX2    = 4;
  localparam int F_SPDIF  = 5;
  localparam int LEVEL_W  = 3;
  localparam int AS_IN1   = 6;
  localparam int AS_IN2   = 7;
  localparam int AS_TX1   = 8;
  localparam int AS_TX2   = 9;
  localparam int AS_SPDIF = 10;
  localparam int AS_IN3   = 12;
  localparam int TSRC_HI  = 11;
  localparam int TSRC_MSB = 2;
  localparam int TSRC_LSB = 0;
  localparam int TCNT_MSB = 5;
  localparam int TCNT_LSB = 3;
  localparam logic [2:0] TCNT_MAX      = 3'h4;
  localparam logic [3:0] TSRC_OFF      = 4'h0;
  localparam logic [3:0] TSRC_RESERVED = 4'h6;
  localparam logic [3:0] TSRC_LAST     = 4'h8;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int ST_TX1_UO   = 31;
  localparam int ST_TX1_RS   = 30;
  localparam int ST_TX2_UO   = 29;
  localparam int ST_TX2_RS   = 28;
  localparam int ST_SPD_UO   = 27;
  localparam int ST_SPD_RS   = 26;
  localparam int ST_RX_MSB   = 25;
  localparam int ST_RX_LSB   = 13;
  localparam int ST_UTX_EMPTY = 21;
  localparam int ST_UTX_FIRST = 19;
  localparam int ST_URX_FULL  = 18;
  localparam int ST_QRX_FULL  = 16;
  localparam int ST_IN1_UO   = 12;
  localparam int ST_IN1_RS   = 11;
  localparam int ST_IN2_UO   = 10;
  localparam int ST_IN2_RS   = 9;
  localparam int ST_TICK     = 8;
  localparam logic [31:0] ST_IMPL_MASK = 32'hffff_ff00;
  // bits that the clear register cannot touch
  localparam logic [31:0] ST_SELF_CLR  = 32'h002d_0000;
  // fifo state register fields
  localparam int FS_IN3_UO   = 0;
  localparam int FS_IN3_RS   = 1;
  localparam int FS_FULL_LSB = 2;
  localparam int FS_EMPTY_LSB = 5;

  typedef enum logic [1:0] {RS_OFF, RS_STANDBY, RS_ON} rs_state_t;
endpackage : audio_irq_pkg

// ### tb/cpu_bus_model.sv
// processor software model: apb master issuing whole-word accesses
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // ------------------------------------------------------------
  // one transfer; request held until pready is sampled high
  // ------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; a stuck slave is left to the bench watchdog
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : cpu_bus_model

// ### tb/test_audio_fifo_irq_sync_ctrl.sv
// self-checking bench for the audio fifo control and interrupt block
`timescale 1ns/1ps
module test_audio_fifo_irq_sync_ctrl;
  import audio_irq_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sample_tick = 0, user_tx_write = 0, user_rx_read = 0, subcode_rx_read = 0;
  logic [7:0] tick_events = '0;
  logic [5:0] cpu_access = '0, cpu_xrun = '0, left_audio = '0, right_audio = '0;
  logic [5:0] xrun_left = '0, xrun_right = '0, resync_load, drop_left, drop_right;
  logic [17:0] left_level = '0, right_level = '0;
  logic [2:0] in_left_full = '0, in_right_full = '0, tx_left_empty = '0, tx_right_empty = '0;
  logic [2:0] in_full, tx_empty;
  logic [12:0] rx_event_set = '0;
  logic tick_irq, audio_irq;
  int error_cnt = 0, compares = 0, tick_seen = 0, load_seen = 0, t0;
  logic [31:0] r;
  logic e;
  int srcs[7] = '{1, 2, 3, 4, 5, 7, 8};

  always #50 sys_clk = ~sys_clk;

  cpu_bus_model cpu (.clk(sys_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  audio_fifo_irq_sync_ctrl dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SAMPLE_TICK(sample_tick), .TICK_EVENTS(tick_events),
    .CPU_ACCESS(cpu_access), .CPU_XRUN(cpu_xrun), .LEFT_AUDIO(left_audio),
    .RIGHT_AUDIO(right_audio), .XRUN_LEFT(xrun_left), .XRUN_RIGHT(xrun_right),
    .LEFT_LEVEL(left_level), .RIGHT_LEVEL(right_level), .IN_LEFT_FULL(in_left_full),
    .IN_RIGHT_FULL(in_right_full), .TX_LEFT_EMPTY(tx_left_empty),
    .TX_RIGHT_EMPTY(tx_right_empty), .RX_EVENT_SET(rx_event_set),
    .USER_TX_WRITE(user_tx_write), .USER_RX_READ(user_rx_read),
    .SUBCODE_RX_READ(subcode_rx_read), .IN_FULL(in_full), .TX_EMPTY(tx_empty),
    .RESYNC_LOAD(resync_load), .DROP_LEFT(drop_left), .DROP_RIGHT(drop_right),
    .TICK_IRQ(tick_irq), .AUDIO_IRQ(audio_irq));

  always @(posedge sys_clk) begin
    if (tick_irq === 1'b1) tick_seen++;
    if (resync_load[F_IN1] === 1'b1) load_seen++;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check32

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    cpu.xfer(1'b1, {idx, 2'b00}, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    cpu.xfer(1'b0, {idx, 2'b00}, 32'h0, r, e);
    check32(nm, exp, r);
  endtask : rd_chk

  // one-cycle pulse on the chosen event input
  task automatic strobe(input int k, input int i);
    @(posedge sys_clk);
    case (k)
      0: left_audio[i] <= 1'b1;
      1: right_audio[i] <= 1'b1;
      2: cpu_access[i] <= 1'b1;
      3: sample_tick <= 1'b1;
      4: xrun_left[i] <= 1'b1;
      5: xrun_right[i] <= 1'b1;
      6: tick_events[i] <= 1'b1;
      7: rx_event_set <= '1;
      8: user_tx_write <= 1'b1;
      9: user_rx_read <= 1'b1;
      10: subcode_rx_read <= 1'b1;
      default: cpu_xrun[i] <= 1'b1;
    endcase
    @(posedge sys_clk);
    {left_audio, right_audio, cpu_access, xrun_left, xrun_right, cpu_xrun} <= '0;
    {sample_tick, tick_events, rx_event_set, user_tx_write, user_rx_read} <= '0;
    subcode_rx_read <= 1'b0;
  endtask : strobe

  // left strobe strictly before right, close together
  task automatic resync_try(input bit cpu_between);
    strobe(3, 0);
    strobe(0, F_IN1);
    if (cpu_between) strobe(2, F_IN1);
    strobe(1, F_IN1);
    repeat (4) @(posedge sys_clk);
  endtask : resync_try

  function automatic logic [31:0] tick_ctrl(input logic [3:0] s, input logic [2:0] c);
    return {16'h0, 4'h0, s[3], 5'h0, c, s[2:0]};
  endfunction : tick_ctrl

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk("ctrl_reset", IDX_GLOBAL_CTRL, 32'h0);
    wr(IDX_GLOBAL_CTRL, 32'hffff_ffff);
    rd_chk("ctrl_bits", IDX_GLOBAL_CTRL, 32'h0000_1fff);
    cpu.xfer(1'b0, 12'h000, 32'h0, r, e);
    check32("unmapped_err", 32'h1, {31'h0, e});
    // every defined source, count of one, foreign event ignored
    foreach (srcs[j]) begin
      wr(IDX_GLOBAL_CTRL, tick_ctrl(srcs[j][3:0], 3'h0));
      t0 = tick_seen;
      strobe(6, srcs[j] % 8);
      strobe(6, srcs[j] - 1);
      repeat (3) @(posedge sys_clk);
      check32("tick_src", t0 + 1, tick_seen);
    end
    for (int c = 0; c < 5; c++) begin
      wr(IDX_GLOBAL_CTRL, tick_ctrl(4'h1, 3'h7));
      wr(IDX_GLOBAL_CTRL, tick_ctrl(4'h1, c[2:0]));
      t0 = tick_seen;
      repeat (10) strobe(6, 0);
      repeat (3) @(posedge sys_clk);
      check32("tick_cnt", t0 + 10 / (c + 1), tick_seen);
    end
    // count lowered below events already seen: next event ticks
    wr(IDX_GLOBAL_CTRL, tick_ctrl(4'h1, 3'h4));
    repeat (3) strobe(6, 0);
    wr(IDX_GLOBAL_CTRL, tick_ctrl(4'h1, 3'h0));
    t0 = tick_seen;
    strobe(6, 0);
    repeat (3) @(posedge sys_clk);
    check32("tick_shrink", t0 + 1, tick_seen);
    wr(IDX_GLOBAL_CTRL, 32'h0);
    rd_chk("st_tick", IDX_IRQ_STATUS, 32'h0000_0100);
    wr(IDX_IRQ_CLEAR, 32'h0000_0100);
    rd_chk("st_clr", IDX_IRQ_STATUS, 32'h0);
    // pair full / empty only when both halves agree
    in_left_full <= 3'b111;
    in_right_full <= 3'b010;
    tx_left_empty <= 3'b011;
    tx_right_empty <= 3'b110;
    repeat (2) @(posedge sys_clk);
    check32("in_full", 32'h2, {29'h0, in_full});
    check32("tx_empty", 32'h2, {29'h0, tx_empty});
    strobe(4, F_IN3);
    @(posedge sys_clk);
    check32("drop_right", 32'h1, {31'h0, drop_right[F_IN3]});
    rd_chk("fifo_state", IDX_FIFO_STATE, 32'h0000_0049);
    wr(IDX_FIFO_STATE, 32'h0000_0001);
    rd_chk("fifo_state_clr", IDX_FIFO_STATE, 32'h0000_0048);
    // xrun flags and sample dropping
    strobe(5, F_IN1);
    @(posedge sys_clk);
    check32("drop_left", 32'h1, {31'h0, drop_left[F_IN1]});
    strobe(0, F_IN1);
    @(posedge sys_clk);
    check32("drop_left_clr", 32'h0, {31'h0, drop_left[F_IN1]});
    strobe(4, F_TX1);
    strobe(11, F_IN2);
    rd_chk("st_xrun", IDX_IRQ_STATUS, 32'h8000_1400);
    check32("irq_line", 32'h1, {31'h0, audio_irq});
    wr(IDX_IRQ_CLEAR, 32'hffff_ffff);
    rd_chk("st_xrun_clr", IDX_IRQ_STATUS, 32'h0);
    // auto-resync of input pair 1
    left_level <= 18'h3;
    right_level <= 18'h1;
    wr(IDX_GLOBAL_CTRL, 32'h0000_0040);
    resync_try(1'b0);
    check32("resync_load", 32'h1, load_seen);
    rd_chk("st_resync", IDX_IRQ_STATUS, 32'h0000_0800);
    resync_try(1'b1);
    check32("resync_cpu", 32'h1, load_seen);
    wr(IDX_GLOBAL_CTRL, 32'h0);
    resync_try(1'b0);
    check32("resync_off", 32'h1, load_seen);
    wr(IDX_IRQ_CLEAR, 32'hffff_ffff);
    // receiver and subcode events with their own clearing actions
    strobe(7, 0);
    rd_chk("st_rx", IDX_IRQ_STATUS, 32'h03ff_e000);
    wr(IDX_IRQ_CLEAR, 32'hffff_ffff);
    rd_chk("st_rx_clr", IDX_IRQ_STATUS, 32'h002d_0000);
    strobe(8, 0);
    rd_chk("st_utx", IDX_IRQ_STATUS, 32'h0005_0000);
    strobe(9, 0);
    rd_chk("st_urx", IDX_IRQ_STATUS, 32'h0001_0000);
    strobe(10, 0);
    rd_chk("st_sub", IDX_IRQ_STATUS, 32'h0);
    complete_run();
  end
endmodule : test_audio_fifo_irq_sync_ctrl
